// ---- pkg/eer_defines.svh ----
// constants for the data eeprom erase and read block
`ifndef EER_DEFINES_SVH
`define EER_DEFINES_SVH
// timing
`define EER_CLK_NS       4
`define EER_ERASE_NS     4000000
`define EER_ERASE_CYC    ((`EER_ERASE_NS + `EER_CLK_NS - 1) / `EER_CLK_NS)
`define EER_DISI_LEN     3'h5
// array geometry
`define EER_WORDS        256
`define EER_AW           8
`define EER_DW           16
`define EER_ERASED       16'hffff
`define EER_EE_PAGE      8'h7f
`define EER_EE_HI        7'h7f
// control register fields
`define EER_CTL_WR       15
`define EER_CTL_WREN     14
`define EER_CTL_ERASE    6
`define EER_CTL_RESET    15'h0000
// unlock keys
`define EER_KEY1         16'h0055
`define EER_KEY2         16'h00aa
// controller register offsets
`define EER_A_CTL        4'h0
`define EER_A_KEY        4'h1
`define EER_A_PAGE       4'h2
`define EER_A_WORK       4'h3
`define EER_A_TBLRD      4'h4
`define EER_A_TBLWT      4'h5
`define EER_A_PSV        4'h6
`define EER_A_DATA       4'h7
`define EER_A_STAT       4'h8
`define EER_A_MASK       4'h9
// status bits
`define EER_ST_DONE      0
`define EER_ST_RDY       1
`endif

// ---- pkg/eer_pkg.sv ----
// types shared by both ends of the data eeprom block
package eer_pkg;
    typedef enum logic [1:0] {EER_SZ_ONE, EER_SZ_FOUR, EER_SZ_EIGHT, EER_SZ_ALL} eer_size_e;
    typedef enum logic {EER_SFR_CTRL, EER_SFR_KEY} eer_sfr_e;
    typedef enum logic [1:0] {EER_IDLE, EER_WAIT, EER_APPLY} eer_state_e;
endpackage

// ---- pkg/eer_if.sv ----
// link between the cpu core and the data eeprom access logic
`timescale 1ns/1ps
interface eer_if;
    import eer_pkg::*;
    logic             sfr_wr;
    eer_sfr_e         sfr_sel;
    logic [15:0]      wdata;
    logic [7:0]       tbl_page;
    logic [15:0]      tbl_offset;
    logic             tbl_rd;
    logic             tbl_wr;
    logic             psv_rd;
    logic [15:0]      psv_addr;
    logic [15:0]      rd_data;
    logic             rd_valid;
    logic             done;
    logic [15:0]      nv_ctrl;

    modport dev (input sfr_wr, sfr_sel, wdata, tbl_page, tbl_offset, tbl_rd, tbl_wr,
                 psv_rd, psv_addr, output rd_data, rd_valid, done, nv_ctrl);
    modport cpu (output sfr_wr, sfr_sel, wdata, tbl_page, tbl_offset, tbl_rd, tbl_wr,
                 psv_rd, psv_addr, input rd_data, rd_valid, done, nv_ctrl);
endinterface // eer_if

// ---- logic/eer_unlock.sv ----
// unlock key sequence tracker
`timescale 1ns/1ps
`include "eer_defines.svh"
module eer_unlock
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        wr_i,
    input  wire logic        key_sel_i,
    input  wire logic [15:0] data_i,
    output logic             armed_o
);
    logic stage_reg;
    logic armed_reg;

    // ------------------------------------------------
    // key sequence: first key, second key, then one write
    // ------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            stage_reg <= 1'b0;
            armed_reg <= 1'b0;
        end
        else if (wr_i)
        begin
            stage_reg <= key_sel_i && data_i == `EER_KEY1;
            armed_reg <= key_sel_i && data_i == `EER_KEY2 && stage_reg;
        end
    end

    assign armed_o = armed_reg;
endmodule // eer_unlock

// ---- logic/eer_device.sv ----
// data eeprom array with erase, program and read access
//
// Notes on behaviour
// - erase one, four, eight words or all
// - control bits one and zero pick size
// - software sets control register before erase
// - software loads page and working register first
// - software clears done flag, optional interrupt
// - key sequence written just before start
// - start bit after unlock begins erase
// - completion sets done flag, clears start
// - single-word erase uses documented control value
// - interrupts blocked five instructions around unlock
// - words sixteen bits, low read suffices
// - page, working register, low table read
// - eeprom also readable through visibility window
`timescale 1ns/1ps
`include "eer_defines.svh"
module eer_device
#(
    parameter int unsigned ERASE_CYCLES = `EER_ERASE_CYC
)
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    eer_if.dev               link,
    output eer_pkg::eer_state_e state_o,
    output logic             busy_o
);
    import eer_pkg::*;

    // ------------------------------------------------
    // decoding helpers
    // ------------------------------------------------
    function automatic logic [`EER_AW:0] eer_span(input eer_size_e s);
        case (s)
            EER_SZ_ONE:   eer_span = 9'h001;
            EER_SZ_FOUR:  eer_span = 9'h004;
            EER_SZ_EIGHT: eer_span = 9'h008;
            default:      eer_span = 9'h100;
        endcase
    endfunction

    function automatic logic eer_hit(input logic [15:0] a);
        eer_hit = a[15:9] == `EER_EE_HI;
    endfunction

    // ------------------------------------------------
    // storage and state
    // ------------------------------------------------
    logic [`EER_DW-1:0] mem [`EER_WORDS];
    eer_state_e         state_reg;
    logic [14:0]        ctl_reg;
    logic               wr_reg;
    logic [31:0]        wait_reg;
    logic [`EER_AW:0]   left_reg;
    logic [`EER_AW-1:0] ptr_reg;
    logic               erase_reg;
    logic [`EER_DW-1:0] latch_reg;
    logic [`EER_AW-1:0] latch_addr_reg;
    logic [`EER_DW-1:0] rd_data_reg;
    logic               rd_valid_reg;
    logic               done_reg;
    logic               armed;
    logic               ctl_wr;
    logic               go;
    logic               tbl_ok;
    logic [`EER_AW:0]   span;
    eer_size_e          size;

    eer_unlock u_unlock
    (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .wr_i      (link.sfr_wr),
        .key_sel_i (link.sfr_sel == EER_SFR_KEY),
        .data_i    (link.wdata),
        .armed_o   (armed)
    );

    assign ctl_wr = link.sfr_wr && link.sfr_sel == EER_SFR_CTRL;
    assign size   = eer_size_e'(ctl_reg[1:0]);
    assign span   = eer_span(size);
    assign tbl_ok = link.tbl_page == `EER_EE_PAGE && eer_hit(link.tbl_offset);
    // start needs write enable and the unlock as the write just before
    assign go = ctl_wr && link.wdata[`EER_CTL_WR] && link.wdata[`EER_CTL_WREN]
                && armed && state_reg == EER_IDLE;

    // ------------------------------------------------
    // control register
    // ------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            ctl_reg <= `EER_CTL_RESET;
        else if (ctl_wr && state_reg == EER_IDLE)
            ctl_reg <= link.wdata[14:0];
    end

    // ------------------------------------------------
    // start bit: set on accepted start, cleared on completion
    // ------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            wr_reg <= 1'b0;
        else if (go)
            wr_reg <= 1'b1;
        else if (state_reg == EER_APPLY && left_reg == 9'h001)
            wr_reg <= 1'b0;
    end

    // ------------------------------------------------
    // write latch from low table write
    // ------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            latch_reg      <= '0;
            latch_addr_reg <= '0;
        end
        else if (link.tbl_wr && tbl_ok && state_reg == EER_IDLE)
        begin
            latch_reg      <= link.wdata;
            latch_addr_reg <= link.tbl_offset[`EER_AW:1];
        end
    end

    // ------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_reg <= EER_IDLE;
            wait_reg  <= '0;
            left_reg  <= '0;
            ptr_reg   <= '0;
            erase_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                EER_IDLE:
                begin
                    if (go)
                    begin
                        state_reg <= EER_WAIT;
                        wait_reg  <= ERASE_CYCLES - 1;
                        erase_reg <= ctl_reg[`EER_CTL_ERASE];
                        if (ctl_reg[`EER_CTL_ERASE])
                        begin
                            // align to the block size, a full erase starts at zero
                            left_reg <= span;
                            ptr_reg  <= latch_addr_reg & ~span[`EER_AW-1:0] + 8'h01;
                        end
                        else
                        begin
                            left_reg <= 9'h001;
                            ptr_reg  <= latch_addr_reg;
                        end
                    end
                end
                EER_WAIT:
                begin
                    if (wait_reg == 32'h0)
                        state_reg <= EER_APPLY;
                    else
                        wait_reg <= wait_reg - 32'h1;
                end
                EER_APPLY:
                begin
                    ptr_reg  <= ptr_reg + 8'h01;
                    left_reg <= left_reg - 9'h001;
                    if (left_reg == 9'h001)
                        state_reg <= EER_IDLE;
                end
                default:
                    state_reg <= EER_IDLE;
            endcase
        end
    end

    // ------------------------------------------------
    // array write port
    // ------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (state_reg == EER_APPLY)
            mem[ptr_reg] <= erase_reg ? `EER_ERASED : latch_reg;
    end

    // ------------------------------------------------
    // completion pulse
    // ------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            done_reg <= 1'b0;
        else
            done_reg <= state_reg == EER_APPLY && left_reg == 9'h001;
    end

    // ------------------------------------------------
    // read port: low table read and visibility window
    // ------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            rd_valid_reg <= 1'b0;
            rd_data_reg  <= '0;
        end
        else
        begin
            rd_valid_reg <= link.tbl_rd || link.psv_rd;
            if (link.tbl_rd)
                rd_data_reg <= tbl_ok ? mem[link.tbl_offset[`EER_AW:1]] : '0;
            else if (link.psv_rd)
                rd_data_reg <= eer_hit(link.psv_addr) ? mem[link.psv_addr[`EER_AW:1]]
                                                      : '0;
        end
    end

    assign link.rd_data  = rd_data_reg;
    assign link.rd_valid = rd_valid_reg;
    assign link.done     = done_reg;
    assign link.nv_ctrl  = {wr_reg, ctl_reg};
    assign state_o       = state_reg;
    assign busy_o        = wr_reg;
endmodule // eer_device

// ---- logic/eer_cpu.sv ----
// cpu core end: software registers driving the data eeprom link
`timescale 1ns/1ps
`include "eer_defines.svh"
module eer_cpu
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o,
    output logic             irq_o,
    eer_if.cpu               link
);
    import eer_pkg::*;

    logic        sfr_wr_reg;
    eer_sfr_e    sfr_sel_reg;
    logic [15:0] wdata_reg;
    logic        tbl_rd_reg;
    logic        tbl_wr_reg;
    logic        psv_rd_reg;
    logic [15:0] psv_addr_reg;
    logic [7:0]  page_reg;
    logic [15:0] work_reg;
    logic [15:0] data_reg;
    logic [1:0]  stat_reg;
    logic [1:0]  mask_reg;
    logic [1:0]  ev;
    logic [2:0]  disi_reg;
    logic [15:0] rdata_reg;
    logic        irq_reg;

    // ------------------------------------------------
    // forwarding of software writes onto the link
    // ------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            sfr_wr_reg   <= 1'b0;
            sfr_sel_reg  <= EER_SFR_CTRL;
            wdata_reg    <= '0;
            tbl_rd_reg   <= 1'b0;
            tbl_wr_reg   <= 1'b0;
            psv_rd_reg   <= 1'b0;
            psv_addr_reg <= '0;
        end
        else
        begin
            sfr_wr_reg <= wr_i && (addr_i == `EER_A_CTL || addr_i == `EER_A_KEY);
            sfr_sel_reg <= (addr_i == `EER_A_KEY) ? EER_SFR_KEY : EER_SFR_CTRL;
            tbl_rd_reg <= wr_i && addr_i == `EER_A_TBLRD;
            tbl_wr_reg <= wr_i && addr_i == `EER_A_TBLWT;
            psv_rd_reg <= wr_i && addr_i == `EER_A_PSV;
            if (wr_i)
                wdata_reg <= wdata_i;
            if (wr_i && addr_i == `EER_A_PSV)
                psv_addr_reg <= wdata_i;
        end
    end

    // ------------------------------------------------
    // table pointer and read result
    // ------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            page_reg <= '0;
            work_reg <= '0;
            data_reg <= '0;
        end
        else
        begin
            if (wr_i && addr_i == `EER_A_PAGE)
                page_reg <= wdata_i[7:0];
            if (wr_i && addr_i == `EER_A_WORK)
                work_reg <= wdata_i;
            if (link.rd_valid)
                data_reg <= link.rd_data;
        end
    end

    // ------------------------------------------------
    // sticky status, set wins over write-one clear
    // ------------------------------------------------
    assign ev = {link.rd_valid, link.done};

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            stat_reg <= '0;
            mask_reg <= '0;
        end
        else
        begin
            if (wr_i && addr_i == `EER_A_STAT)
                stat_reg <= (stat_reg & ~wdata_i[1:0]) | ev;
            else
                stat_reg <= stat_reg | ev;
            if (wr_i && addr_i == `EER_A_MASK)
                mask_reg <= wdata_i[1:0];
        end
    end

    // ------------------------------------------------
    // interrupt, held off around the unlock sequence
    // ------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            disi_reg <= '0;
        else if (wr_i && addr_i == `EER_A_KEY)
            disi_reg <= `EER_DISI_LEN;
        else if (disi_reg != 3'h0)
            disi_reg <= disi_reg - 3'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(stat_reg & mask_reg) && disi_reg == 3'h0;
    end

    // ------------------------------------------------
    // read data, one cycle after the read strobe
    // ------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            rdata_reg <= '0;
        else if (rd_i)
        begin
            case (addr_i)
                `EER_A_CTL:  rdata_reg <= link.nv_ctrl;
                `EER_A_PAGE: rdata_reg <= {8'h00, page_reg};
                `EER_A_WORK: rdata_reg <= work_reg;
                `EER_A_DATA: rdata_reg <= data_reg;
                `EER_A_STAT: rdata_reg <= {14'h0000, stat_reg};
                `EER_A_MASK: rdata_reg <= {14'h0000, mask_reg};
                default:     rdata_reg <= '0;
            endcase
        end
        else
            rdata_reg <= '0;
    end

    assign link.sfr_wr     = sfr_wr_reg;
    assign link.sfr_sel    = sfr_sel_reg;
    assign link.wdata      = wdata_reg;
    assign link.tbl_page   = page_reg;
    assign link.tbl_offset = work_reg;
    assign link.tbl_rd     = tbl_rd_reg;
    assign link.tbl_wr     = tbl_wr_reg;
    assign link.psv_rd     = psv_rd_reg;
    assign link.psv_addr   = psv_addr_reg;
    assign rdata_o         = rdata_reg;
    assign irq_o           = irq_reg;
endmodule // eer_cpu

// ---- verif/eer_properties.sv ----
// concurrent checks on the link between the cpu end and the eeprom device
`timescale 1ns/1ps
module eer_properties
#(
    parameter int ERASE_CYCLES = 20
)
(
    input logic              clk_i,
    input logic              reset_i,
    input logic              sfr_wr,
    input eer_pkg::eer_sfr_e sfr_sel,
    input logic [15:0]       wdata,
    input logic [7:0]        tbl_page,
    input logic [15:0]       tbl_offset,
    input logic              tbl_rd,
    input logic              tbl_wr,
    input logic              psv_rd,
    input logic [15:0]       psv_addr,
    input logic [15:0]       rd_data,
    input logic              rd_valid,
    input logic              done,
    input logic [15:0]       nv_ctrl
);
    import eer_pkg::*;
    localparam int ERASE_LO = ERASE_CYCLES;
    localparam int ERASE_HI = ERASE_CYCLES + 300;
    logic key1_reg;
    logic key2_reg;

    // ----------------------------------------
    // unlock tracking: last two control/key writes
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            key1_reg <= 1'b0;
            key2_reg <= 1'b0;
        end
        else if (sfr_wr)
        begin
            key1_reg <= (sfr_sel == EER_SFR_KEY) && (wdata == 16'h0055);
            key2_reg <= (sfr_sel == EER_SFR_KEY) && (wdata == 16'h00aa) && key1_reg;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    tbl_answer_a: assert property (tbl_rd |=> rd_valid)
        else $error("table read not answered next cycle");
    psv_answer_a: assert property (psv_rd |=> rd_valid)
        else $error("window read not answered next cycle");
    valid_cause_a: assert property (rd_valid |-> $past(tbl_rd) || $past(psv_rd))
        else $error("read valid without a read request");
    tbl_outside_a: assert property (tbl_rd && tbl_page != 8'h7f |=> rd_data == 16'h0000)
        else $error("table read outside eeprom page not zero");
    psv_outside_a: assert property (psv_rd && psv_addr[15:9] != 7'h7f |=> rd_data == 16'h0000)
        else $error("window read outside eeprom not zero");
    data_hold_a: assert property (!tbl_rd && !psv_rd |=> $stable(rd_data))
        else $error("read data changed without a read");
    start_unlock_a: assert property ($rose(nv_ctrl[15]) |->
        $past(sfr_wr && sfr_sel == EER_SFR_CTRL && key2_reg && wdata[14]))
        else $error("start without unlock sequence");
    done_clears_a: assert property (done |-> !nv_ctrl[15] && $past(nv_ctrl[15]))
        else $error("done without clearing start bit");
    busy_until_done_a: assert property ($fell(nv_ctrl[15]) |-> done)
        else $error("start bit dropped without done");
    ctrl_frozen_a: assert property (nv_ctrl[15] && $past(nv_ctrl[15]) |->
        nv_ctrl[14:0] == $past(nv_ctrl[14:0]))
        else $error("control changed while busy");
    erase_time_a: assert property ($rose(nv_ctrl[15]) |-> ##[ERASE_LO:ERASE_HI] done)
        else $error("operation length out of range");
endmodule // eer_properties

// ---- verif/data_eeprom_erase_read_tb.sv ----
// self-checking bench for the data eeprom erase and read block
`timescale 1ns/1ps
`include "eer_defines.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module data_eeprom_erase_read_tb;
    import eer_pkg::*;
    localparam int ERASE_CYC = 20;
    logic        clk_i   = 1'b0;
    logic        reset_i = 1'b1;
    logic [3:0]  addr_i  = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i    = 1'b0;
    logic        rd_i    = 1'b0;
    logic [15:0] rdata_o;
    logic        irq_o;
    eer_state_e  state;
    logic        busy;
    logic [15:0] model_mem [256];
    logic        mask_v  = 1'b1;
    logic [15:0] v;
    int          seed    = 32'h7d18;
    int          n_mismatch = 0;
    int          n_checks   = 0;
    int          cycles     = 0;

    eer_if lnk ();
    eer_device #(.ERASE_CYCLES(ERASE_CYC)) u_eer_device (.clk_i(clk_i), .reset_i(reset_i),
        .link(lnk), .state_o(state), .busy_o(busy));
    eer_cpu u_eer_cpu (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .link(lnk));
    eer_properties #(.ERASE_CYCLES(ERASE_CYC)) u_eer_properties (.clk_i(clk_i),
        .reset_i(reset_i), .sfr_wr(lnk.sfr_wr), .sfr_sel(lnk.sfr_sel), .wdata(lnk.wdata),
        .tbl_page(lnk.tbl_page), .tbl_offset(lnk.tbl_offset), .tbl_rd(lnk.tbl_rd),
        .tbl_wr(lnk.tbl_wr), .psv_rd(lnk.psv_rd), .psv_addr(lnk.psv_addr),
        .rd_data(lnk.rd_data), .rd_valid(lnk.rd_valid), .done(lnk.done), .nv_ctrl(lnk.nv_ctrl));

    always #2 clk_i = ~clk_i;

    // ----------------------------------------
    // verdict and hang guard
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // software port cycles
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask

    // mode 0: no keys, 1: proper keys, 2: keys reversed
    task automatic nv_start(input logic [15:0] ctl, input int idx, input logic [15:0] d,
                            input int mode);
        wr(`EER_A_CTL, ctl);
        wr(`EER_A_PAGE, {8'h00, `EER_EE_PAGE});
        wr(`EER_A_WORK, {`EER_EE_HI, idx[7:0], 1'b0});
        wr(`EER_A_TBLWT, d);
        if (mode != 0)
            wr(`EER_A_KEY, (mode == 1) ? `EER_KEY1 : `EER_KEY2);
        if (mode != 0)
            wr(`EER_A_KEY, (mode == 1) ? `EER_KEY2 : `EER_KEY1);
        wr(`EER_A_CTL, ctl | 16'h8000);
    endtask

    task automatic nv_finish(input logic started);
        logic [15:0] s;
        int n;
        n = 0;
        rd(`EER_A_CTL, s);
        `CHK("start bit", started, s[15])
        while (s[15] === 1'b1 && n < 400)
        begin
            rd(`EER_A_CTL, s);
            n++;
        end
        `CHK("start bit cleared", 1'b0, s[15])
        `CHK("state idle", EER_IDLE, state)
        rd(`EER_A_STAT, s);
        `CHK("done flag", started, s[0])
        `CHK("irq", started & mask_v, irq_o)
        wr(`EER_A_STAT, 16'h0003);
        @(posedge clk_i);
        #1 `CHK("irq cleared", 1'b0, irq_o)
    endtask

    task automatic model_erase(input int sz, input int idx);
        int n;
        n = (sz == 3) ? 256 : (sz == 2) ? 8 : (sz == 1) ? 4 : 1;
        for (int i = 0; i < n; i++)
            model_mem[(idx & ~(n - 1)) + i] = `EER_ERASED;
    endtask

    task automatic program_word(input int idx);
        logic [15:0] d;
        d = 16'($random(seed));
        nv_start(16'h4000, idx, d, 1);
        nv_finish(1'b1);
        model_mem[idx] = d;
    endtask

    task automatic check_word(input int idx, input bit program_space_window);
        logic [15:0] r;
        if (program_space_window)
            wr(`EER_A_PSV, {`EER_EE_HI, idx[7:0], 1'b0});
        else
            wr(`EER_A_WORK, {`EER_EE_HI, idx[7:0], 1'b0});
        if (!program_space_window)
            wr(`EER_A_TBLRD, 16'h0000);
        // the result reaches the data register two edges after the request
        @(posedge clk_i);
        rd(`EER_A_DATA, r);
        if (program_space_window)
            `CHK("window word", model_mem[idx], r)
        else
            `CHK("table word", model_mem[idx], r)
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        wr(`EER_A_MASK, 16'h0001);
        nv_start(16'h4043, 0, 16'h0000, 1);
        nv_finish(1'b1);
        model_erase(3, 0);
        for (int i = 0; i < 16; i++)
            program_word(i);
        for (int i = 0; i < 16; i++)
            check_word(i, i[0]);
        check_word(255, 1'b0);
        $display("test full erase and program done");
        for (int sz = 0; sz < 3; sz++)
        begin
            for (int i = 0; i < 16; i++)
                program_word(i);
            nv_start((sz == 0) ? 16'h4058 : (16'h4040 | 16'(sz)), 5, 16'h0000, 1);
            nv_finish(1'b1);
            model_erase(sz, 5);
            for (int i = 0; i < 16; i++)
                check_word(i, 1'b0);
        end
        $display("test partial erase sizes done");
        for (int m = 0; m < 3; m++)
        begin
            // mode 1 keeps the keys but leaves write enable clear
            nv_start((m == 1) ? 16'h0000 : 16'h4000, 3, 16'h1234, m);
            nv_finish(1'b0);
            check_word(3, 1'b0);
        end
        $display("test refused start done");
        nv_start(16'h4043, 0, 16'h0000, 1);
        wr(`EER_A_CTL, 16'h4000);
        wr(`EER_A_KEY, `EER_KEY1);
        wr(`EER_A_KEY, `EER_KEY2);
        wr(`EER_A_CTL, 16'hc000);
        rd(`EER_A_CTL, v);
        `CHK("control while busy", 16'hc043, v)
        `CHK("busy", 1'b1, busy)
        `CHK("state busy", 1'b1, state != EER_IDLE)
        nv_finish(1'b1);
        model_erase(3, 0);
        check_word(9, 1'b1);
        $display("test busy lockout done");
        mask_v = 1'b0;
        wr(`EER_A_MASK, 16'h0000);
        program_word(7);
        check_word(7, 1'b1);
        rd(`EER_A_STAT, v);
        `CHK("read ready flag", 1'b1, v[1])
        $display("test masked interrupt done");
        wr(`EER_A_PAGE, 16'h0000);
        wr(`EER_A_TBLRD, 16'h0000);
        @(posedge clk_i);
        rd(`EER_A_DATA, v);
        `CHK("table outside page", 16'h0000, v)
        wr(`EER_A_PSV, 16'h0000);
        @(posedge clk_i);
        rd(`EER_A_DATA, v);
        `CHK("window outside eeprom", 16'h0000, v)
        rd(4'hf, v);
        `CHK("unmapped read", 16'h0000, v)
        $display("test outside reads done");
        tally_and_finish();
    end
endmodule // data_eeprom_erase_read_tb
